// >>> core/prl_bank.sv
// Purpose: Priority registers for DMA channel 2 and scanner, with write lock
// Assumes: Unlock sequence is checked outside; unlock_ok qualifies lock writes
// Notes: Read data valid in the cycle after the read strobe only
//
// How it works
// - DMA channel priority, three bits 2:0
// - Scanner priority, three bits 2:0
// - Reset loads 011, 100, lock zero
// - Unimplemented upper bits read zero
// - Lock clear allows priority writes
// - Lock set ignores priority writes
// - Lock changes only after unlock sequence
// - Lock-once option blocks clearing lock
// - Reset clears lock, re-arms one set
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module prl_bank (
    input wire logic clk,
    input wire logic rst,
    input wire prl_pkg::prl_req_t req,
    input wire logic unlock_ok,
    input wire logic lock_once_option,
    output logic [7:0] rdata,
    output logic [2:0] dma_channel2_priority,
    output logic [2:0] scanner_priority,
    output logic priority_lock_bit
);
    logic [2:0] dma_ff;
    logic [2:0] scan_ff;
    logic lock_ff;
    logic once_ff;
    logic once_cap_ff;
    logic [7:0] rdata_ff;
    logic [2:0] nxt_dma;
    logic [2:0] nxt_scan;
    logic nxt_lock;
    logic [7:0] nxt_rdata;

    // Option comes from outside the clock domain; two stages before use
    logic opt_meta_ff;
    logic opt_sync_ff;
    always_ff @(posedge clk) begin
        opt_meta_ff <= lock_once_option;
        opt_sync_ff <= opt_meta_ff;
    end

    // Address decode
    wire hit_dma = req.addr == prl_pkg::OFF_DMA2_PRIO;
    wire hit_scan = req.addr == prl_pkg::OFF_SCAN_PRIO;
    wire hit_lock = req.addr == prl_pkg::OFF_LOCK_CTRL;
    wire wr_dma = req.wr && hit_dma && !lock_ff;
    wire wr_scan = req.wr && hit_scan && !lock_ff;
    wire lock_val = req.wdata[prl_pkg::LOCK_BIT];
    // Clearing is refused under lock-once so a stray unlock cannot reopen it
    wire clr_block = once_ff && lock_ff && !lock_val;
    wire wr_lock = req.wr && hit_lock && unlock_ok && !clr_block;

    // Next values
    assign nxt_dma = wr_dma ? req.wdata[2:0] : dma_ff;
    assign nxt_scan = wr_scan ? req.wdata[2:0] : scan_ff;
    assign nxt_lock = wr_lock ? lock_val : lock_ff;
    // Unmapped reads return zero; upper bits always zero
    assign nxt_rdata = !req.rd ? 8'h00 :
        hit_dma ? {5'h00, dma_ff} :
        hit_scan ? {5'h00, scan_ff} :
        hit_lock ? {7'h00, lock_ff} : 8'h00;

    // Registers; reset re-arms one set since lock returns to zero
    always_ff @(posedge clk) begin
        if (rst) begin
            dma_ff <= prl_pkg::RST_DMA2_PRIO;
            scan_ff <= prl_pkg::RST_SCAN_PRIO;
            lock_ff <= prl_pkg::RST_LOCK;
            once_cap_ff <= 1'b1;
            once_ff <= 1'b0;
            rdata_ff <= 8'h00;
        end else begin
            dma_ff <= nxt_dma;
            scan_ff <= nxt_scan;
            lock_ff <= nxt_lock;
            once_cap_ff <= 1'b0;
            // Option caught at the first edge after reset release
            if (once_cap_ff) begin
                once_ff <= opt_sync_ff;
            end
            rdata_ff <= nxt_rdata;
        end
    end

    assign rdata = rdata_ff;
    assign dma_channel2_priority = dma_ff;
    assign scanner_priority = scan_ff;
    assign priority_lock_bit = lock_ff;

    property p_locked_hold;
        @(posedge clk) disable iff (rst)
        lock_ff && req.wr && (hit_dma || hit_scan) |=> $stable(dma_ff) && $stable(scan_ff);
    endproperty
    a_locked_hold: assert property (p_locked_hold) else $error("priority changed while locked");

    property p_open_write;
        @(posedge clk) disable iff (rst)
        !lock_ff && req.wr && hit_dma |=> dma_ff == $past(req.wdata[2:0]);
    endproperty
    a_open_write: assert property (p_open_write) else $error("dma priority write lost");

    property p_scan_write;
        @(posedge clk) disable iff (rst)
        !lock_ff && req.wr && hit_scan |=> scan_ff == $past(req.wdata[2:0]);
    endproperty
    a_scan_write: assert property (p_scan_write) else $error("scanner priority write lost");

    property p_need_unlock;
        @(posedge clk) disable iff (rst)
        !unlock_ok |=> $stable(lock_ff);
    endproperty
    a_need_unlock: assert property (p_need_unlock) else $error("lock changed without unlock");

    property p_once;
        @(posedge clk) disable iff (rst)
        once_ff && lock_ff |=> lock_ff;
    endproperty
    a_once: assert property (p_once) else $error("lock cleared under lock-once");

    property p_reset_vals;
        @(posedge clk)
        rst |=> dma_ff == 3'h3 && scan_ff == 3'h4 && !lock_ff;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");

    property p_rd_upper;
        @(posedge clk) disable iff (rst)
        req.rd ##1 1'b1 |-> rdata[7:3] == 5'h00;
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper bits not zero");

    property p_lock_set;
        @(posedge clk) disable iff (rst)
        req.wr && hit_lock && unlock_ok && req.wdata[0] |=> lock_ff;
    endproperty
    a_lock_set: assert property (p_lock_set) else $error("lock set missed");

    property p_rd_lock;
        @(posedge clk) disable iff (rst)
        req.rd && hit_lock |=> rdata == {7'h00, $past(lock_ff)};
    endproperty
    a_rd_lock: assert property (p_rd_lock) else $error("lock readback wrong");

    // Read path: data only in the cycle after the strobe, zero otherwise
    property p_rd_idle;
        @(posedge clk) disable iff (rst)
        !req.rd |=> rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without strobe");

    property p_rd_dma;
        @(posedge clk) disable iff (rst)
        req.rd && hit_dma |=> rdata == {5'h00, $past(dma_ff)};
    endproperty
    a_rd_dma: assert property (p_rd_dma) else $error("dma priority readback wrong");

    property p_rd_scan;
        @(posedge clk) disable iff (rst)
        req.rd && hit_scan |=> rdata == {5'h00, $past(scan_ff)};
    endproperty
    a_rd_scan: assert property (p_rd_scan) else $error("scanner readback wrong");

    property p_rd_lock_upper;
        @(posedge clk) disable iff (rst)
        req.rd && hit_lock |=> rdata[7:1] == 7'h00;
    endproperty
    a_rd_lock_upper: assert property (p_rd_lock_upper) else $error("lock upper bits set");

    property p_rd_unmapped;
        @(posedge clk) disable iff (rst)
        req.rd && !hit_dma && !hit_scan && !hit_lock |=> rdata == 8'h00;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

    property p_rd_no_side;
        @(posedge clk) disable iff (rst)
        req.rd && !req.wr |=> $stable(dma_ff) && $stable(scan_ff) && $stable(lock_ff);
    endproperty
    a_rd_no_side: assert property (p_rd_no_side) else $error("read changed a register");

    // Priority registers move only on their own accepted write
    property p_dma_hold;
        @(posedge clk) disable iff (rst)
        !(req.wr && hit_dma) |=> $stable(dma_ff);
    endproperty
    a_dma_hold: assert property (p_dma_hold) else $error("dma priority moved");

    property p_scan_hold;
        @(posedge clk) disable iff (rst)
        !(req.wr && hit_scan) |=> $stable(scan_ff);
    endproperty
    a_scan_hold: assert property (p_scan_hold) else $error("scanner priority moved");

    property p_dma_locked;
        @(posedge clk) disable iff (rst)
        lock_ff && req.wr && hit_dma |=> $stable(dma_ff);
    endproperty
    a_dma_locked: assert property (p_dma_locked) else $error("dma written while locked");

    property p_scan_locked;
        @(posedge clk) disable iff (rst)
        lock_ff && req.wr && hit_scan |=> $stable(scan_ff);
    endproperty
    a_scan_locked: assert property (p_scan_locked) else $error("scanner written while locked");

    property p_wr_unmapped;
        @(posedge clk) disable iff (rst)
        req.wr && !hit_dma && !hit_scan && !hit_lock |=>
            $stable(dma_ff) && $stable(scan_ff) && $stable(lock_ff);
    endproperty
    a_wr_unmapped: assert property (p_wr_unmapped) else $error("unmapped write took effect");

    property p_dma_only;
        @(posedge clk) disable iff (rst)
        wr_dma |=> $stable(scan_ff) && $stable(lock_ff);
    endproperty
    a_dma_only: assert property (p_dma_only) else $error("dma write leaked");

    property p_scan_only;
        @(posedge clk) disable iff (rst)
        wr_scan |=> $stable(dma_ff) && $stable(lock_ff);
    endproperty
    a_scan_only: assert property (p_scan_only) else $error("scanner write leaked");

    // Lock bit: unlock qualifier, lock-once refusal and re-arm
    property p_lock_only;
        @(posedge clk) disable iff (rst)
        wr_lock |=> $stable(dma_ff) && $stable(scan_ff);
    endproperty
    a_lock_only: assert property (p_lock_only) else $error("lock write leaked");

    property p_lock_idle;
        @(posedge clk) disable iff (rst)
        !(req.wr && hit_lock) |=> $stable(lock_ff);
    endproperty
    a_lock_idle: assert property (p_lock_idle) else $error("lock moved without write");

    property p_lock_no_unlock;
        @(posedge clk) disable iff (rst)
        req.wr && hit_lock && !unlock_ok |=> $stable(lock_ff);
    endproperty
    a_lock_no_unlock: assert property (p_lock_no_unlock) else $error("lock write unqualified");

    property p_lock_clear_open;
        @(posedge clk) disable iff (rst)
        !once_ff && lock_ff && req.wr && hit_lock && unlock_ok && !req.wdata[0] |=> !lock_ff;
    endproperty
    a_lock_clear_open: assert property (p_lock_clear_open) else $error("lock clear missed");

    property p_lock_clear_refused;
        @(posedge clk) disable iff (rst)
        once_ff && lock_ff && req.wr && hit_lock && unlock_ok && !req.wdata[0] |=> lock_ff;
    endproperty
    a_lock_clear_refused: assert property (p_lock_clear_refused) else $error("lock-once cleared");

    property p_lock_persist;
        @(posedge clk) disable iff (rst)
        lock_ff && !(req.wr && hit_lock) |=> lock_ff;
    endproperty
    a_lock_persist: assert property (p_lock_persist) else $error("lock dropped");

    property p_lock_set_open;
        @(posedge clk) disable iff (rst)
        !lock_ff && req.wr && hit_lock && unlock_ok && req.wdata[0] |=> lock_ff;
    endproperty
    a_lock_set_open: assert property (p_lock_set_open) else $error("open lock set missed");

    property p_once_rearm;
        @(posedge clk) disable iff (rst)
        once_ff && !lock_ff && req.wr && hit_lock && unlock_ok && req.wdata[0] |=> lock_ff;
    endproperty
    a_once_rearm: assert property (p_once_rearm) else $error("re-armed set missed");

    // Reset state and option capture
    property p_reset_once;
        @(posedge clk)
        rst |=> once_cap_ff && !once_ff && !lock_ff;
    endproperty
    a_reset_once: assert property (p_reset_once) else $error("reset did not re-arm");

    property p_reset_rd;
        @(posedge clk)
        rst |=> rdata == 8'h00;
    endproperty
    a_reset_rd: assert property (p_reset_rd) else $error("read data not cleared");

    property p_opt_capture;
        @(posedge clk) disable iff (rst)
        once_cap_ff |=> once_ff == $past(opt_sync_ff);
    endproperty
    a_opt_capture: assert property (p_opt_capture) else $error("option not captured");

    property p_cap_oneshot;
        @(posedge clk) disable iff (rst)
        once_cap_ff |=> !once_cap_ff;
    endproperty
    a_cap_oneshot: assert property (p_cap_oneshot) else $error("capture window stuck");

    property p_once_stable;
        @(posedge clk) disable iff (rst)
        !once_cap_ff |=> $stable(once_ff);
    endproperty
    a_once_stable: assert property (p_once_stable) else $error("option moved after capture");
endmodule
`default_nettype wire

// >>> shared/prl_pkg.sv
// Purpose: Constants and types for the priority register lock bank
// Assumes: 8-bit register bus, word index addressing
// Notes: Offsets are local choices
package prl_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int PRIO_W = 3;
    // Register offsets
    localparam logic [3:0] OFF_DMA2_PRIO = 4'h0;
    localparam logic [3:0] OFF_SCAN_PRIO = 4'h1;
    localparam logic [3:0] OFF_LOCK_CTRL = 4'h2;
    // Field positions
    localparam int PRIO_LSB = 0;
    localparam int LOCK_BIT = 0;
    // Reset values
    localparam logic [2:0] RST_DMA2_PRIO = 3'h3;
    localparam logic [2:0] RST_SCAN_PRIO = 3'h4;
    localparam logic RST_LOCK = 1'b0;

    // Register bus request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } prl_req_t;
endpackage

// >>> sim/prl_bank_tb.sv
// Purpose: Self-checking bench for the priority lock bank
// Assumes: Offsets from prl_pkg
// Notes: Unlock qualifier driven straight with each write
`timescale 1ns/10ps
`default_nettype none
module prl_bank_tb;
    localparam logic [3:0] A_D = prl_pkg::OFF_DMA2_PRIO;
    localparam logic [3:0] A_S = prl_pkg::OFF_SCAN_PRIO;
    localparam logic [3:0] A_L = prl_pkg::OFF_LOCK_CTRL;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic unlock_ok = 1'b0;
    logic opt = 1'b0;
    prl_pkg::prl_req_t req = '0;
    logic [7:0] rdata;
    logic [2:0] dma_q;
    logic [2:0] scan_q;
    logic lock_q;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;
    prl_bank uut (.clk(clk), .rst(rst), .req(req), .unlock_ok(unlock_ok),
        .lock_once_option(opt), .rdata(rdata), .dma_channel2_priority(dma_q),
        .scanner_priority(scan_q), .priority_lock_bit(lock_q));
    // 25 MHz clock
    always #20 clk = ~clk;
    // Ceiling far above the 73 cycles the sequence needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            mismatches++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (mismatches == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Option changes only while reset is held
    task automatic do_reset(input logic o);
        @(posedge clk);
        rst <= 1'b1;
        opt <= o;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
    endtask
    task automatic bus_wr(input logic [3:0] a, input logic [7:0] d, input logic u);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        unlock_ok <= u;
        @(posedge clk);
        req.wr <= 1'b0;
        unlock_ok <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1 check(rdata, exp);
    endtask
    // Main sequence
    initial begin
        do_reset(1'b0);
        bus_rd(A_D, 8'h03);
        bus_rd(A_S, 8'h04);
        bus_rd(A_L, 8'h00);
        bus_rd(4'hF, 8'h00);
        bus_wr(A_D, 8'hFD, 1'b0);
        bus_rd(A_D, 8'h05);
        bus_wr(A_S, 8'hFA, 1'b0);
        bus_rd(A_S, 8'h02);
        bus_wr(A_L, 8'h01, 1'b0);
        bus_rd(A_L, 8'h00);
        bus_wr(A_L, 8'hFF, 1'b1);
        bus_rd(A_L, 8'h01);
        bus_wr(A_D, 8'h01, 1'b0);
        bus_wr(A_S, 8'h07, 1'b0);
        #1 check({5'h00, dma_q}, 8'h05);
        bus_rd(A_S, 8'h02);
        check({5'h00, scan_q}, 8'h02);
        bus_wr(A_L, 8'h00, 1'b1);
        bus_rd(A_L, 8'h00);
        do_reset(1'b1);
        bus_rd(A_D, 8'h03);
        bus_wr(A_L, 8'h01, 1'b1);
        bus_wr(A_L, 8'h00, 1'b1);
        bus_rd(A_L, 8'h01);
        do_reset(1'b1);
        #1 check({7'h00, lock_q}, 8'h00);
        bus_wr(A_L, 8'h01, 1'b1);
        bus_rd(A_L, 8'h01);
        stop_test();
    end
endmodule
`default_nettype wire
